// ---- dv/tb_osc_auto_trim_and_switch_ctrl.sv ----
// Self-checking bench for the oscillator auto-trim and clock switch block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fails++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end

module tb_osc_auto_trim_and_switch_ctrl;
  import osc_trim_pkg::*;
  localparam int unsigned EXP = 200;  // Expected count at the centre of the one percent window
  logic clk, arst_n, psel, penable, pwrite, permit, ready, pready, pslverr, xtal_hp, irq, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  clk_sel_t          strap, req_sel, act_sel;
  logic [TRIM_W-1:0] trim, t0;
  logic [7:0]        ph, k;
  int                fails, tests_run;
  // Reference period of 256 clocks; k fast ticks counted in each period
  wire logic ref_clk = (ph < 8'd128);
  wire logic tick    = (ph >= 8'd1) && (ph <= k);

  osc_trim_switch #(.EXP_CNT(EXP)) dut (.CLK(clk), .ARST_N(arst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .RESET_SEL_CFG(strap), .SWITCH_PERMIT_CFG(permit),
    .REF_CLK_IN(ref_clk), .FAST_OSC_TICK(tick), .REQ_OSC_READY(ready), .TRIM_CODE(trim),
    .REQ_SEL(req_sel), .ACTIVE_SEL(act_sel), .XTAL_HIGH_POWER(xtal_hp), .TRIM_IRQ(irq));

  // ---------------------------------------------------------------------------
  // Clock, reference phase and bus tasks
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) ph <= ph + 8'd1;

  task automatic report_and_stop();
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // One transfer; returns at the falling edge so outputs have settled
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      fails++;
      report_and_stop();
    end
    @(negedge clk);
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d); apb(1'b1, idx, d); endtask
  task automatic rdr(input logic [9:0] idx); apb(1'b0, idx, 8'h00); endtask
  task automatic cyc(input int n); repeat (n) @(negedge clk); endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    rdr(IDX_REQ);
    `CHK("request", 32'h60, rd)
    wr(IDX_CUR, 8'h12);
    rdr(IDX_CUR);
    `CHK("active", 32'h60, rd)
    rdr(IDX_SW);
    `CHK("switch ctl", 32'h50, rd)
    `CHK("xtal power", 1'b1, xtal_hp)
    rdr(IDX_ACT);
    `CHK("trim ctl", 32'h0, rd)
    rdr(10'h3FF);
    `CHK("unmapped err", 1'b1, err)
  endtask

  task automatic t_soft_trim();
    wr(IDX_TRIM, 8'h20);
    `CHK("trim min", 6'h20, trim)
    wr(IDX_ACT, 8'h40);
    wr(IDX_TRIM, 8'h05);
    `CHK("trim blocked", 6'h20, trim)
    wr(IDX_ACT, 8'h00);
    wr(IDX_TRIM, 8'h00);
    `CHK("trim nominal", 6'h00, trim)
  endtask

  task automatic t_switch();
    logic [2:0] codes [5];
    codes = '{SRC_EXT, SRC_FAST, SRC_SLOW, SRC_XTAL, SRC_EXT_PLL};
    wr(IDX_REQ, 8'h39);
    `CHK("reserved src", 8'h60, {1'b0, req_sel})
    wr(IDX_REQ, 8'h4A);
    `CHK("reserved div", 8'h60, {1'b0, req_sel})
    wr(IDX_SW, 8'hC0);
    @(posedge clk) ready <= 1'b1;
    wr(IDX_REQ, 8'h49);
    cyc(6);
    `CHK("held active", 8'h60, {1'b0, act_sel})
    rdr(IDX_SW);
    `CHK("held status", 32'hC8, rd)
    wr(IDX_SW, 8'h00);
    cyc(2);
    `CHK("xtal low", 1'b0, xtal_hp)
    `CHK("released", 8'h49, {1'b0, act_sel})
    // Switch through every valid source with the ready line high
    foreach (codes[i]) begin
      wr(IDX_REQ, {1'b0, codes[i], 4'h1});
      cyc(4);
      `CHK("switched", {1'b0, codes[i], 4'h1}, {1'b0, act_sel})
    end
    rdr(IDX_SW);
    `CHK("done status", 32'h10, rd)
    @(posedge clk) permit <= 1'b0;
    wr(IDX_REQ, 8'h52);
    `CHK("pinned request", 8'h60, {1'b0, req_sel})
    @(posedge clk) permit <= 1'b1;
  endtask

  task automatic t_auto_trim();
    wr(IDX_IRQ, 8'h02);
    wr(IDX_ACT, 8'h80);
    cyc(600);
    rdr(IDX_ACT);
    `CHK("locked", 32'h88, rd)
    `CHK("trim kept", 6'h00, trim)
    `CHK("irq on lock", 1'b1, irq)
    wr(IDX_TRIM, 8'h10);
    `CHK("trim ro", 6'h00, trim)
    wr(IDX_ACT, 8'h8A);
    rdr(IDX_ACT);
    `CHK("status ro", 32'h88, rd)
    wr(IDX_IRQ, 8'h03);
    @(posedge clk) k <= 8'd100;
    cyc(600);
    `CHK("irq on unlock", 1'b1, irq)
    wr(IDX_IRQ, 8'h03);
    t0 = trim;
    cyc(768);
    `CHK("trim steps", t0 + 6'd3, trim)
    `CHK("no irq on step", 1'b0, irq)
    wr(IDX_ACT, 8'hC0);
    t0 = trim;
    cyc(768);
    `CHK("trim frozen", t0, trim)
    wr(IDX_ACT, 8'h80);
    cyc(8960);
    `CHK("trim at max", TRIM_MAX, trim)
    rdr(IDX_ACT);
    `CHK("out of range", 32'h82, rd)
    @(posedge clk) k <= 8'd200;
    cyc(640);
    rdr(IDX_ACT);
    `CHK("back in range", 32'h88, rd)
    wr(IDX_ACT, 8'h00);
    rdr(IDX_ACT);
    `CHK("lock off", 32'h0, rd)
  endtask

  initial begin
    {fails, tests_run} = '0;
    {arst_n, psel, penable, pwrite, ready} = '0;
    {paddr, pwdata} = '0;
    permit = 1'b1;
    strap = '{src: SRC_FAST, div: 4'h0};
    {k, ph} = {8'd200, 8'd0};
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_soft_trim();
    t_switch();
    t_auto_trim();
    report_and_stop();
  end

  // Hang guard
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// ---- include/osc_trim_pkg.sv ----
// Constants, field layouts and carrier types of the oscillator trim and switch block
package osc_trim_pkg;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W   = 12;
  localparam logic [9:0]  IDX_REQ  = 10'h28D;  // clock_request_control
  localparam logic [9:0]  IDX_CUR  = 10'h28E;  // clock_current_status
  localparam logic [9:0]  IDX_SW   = 10'h28F;  // clock_switch_control
  localparam logic [9:0]  IDX_TRIM = 10'h292;  // trim_register
  localparam logic [9:0]  IDX_ACT  = 10'h294;  // auto_trim_control
  localparam logic [9:0]  IDX_IRQ  = 10'h295;  // trim_irq_control

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned BIT_ACT_EN   = 7;
  localparam int unsigned BIT_ACT_HOLD = 6;
  localparam int unsigned BIT_ACT_LOCK = 3;
  localparam int unsigned BIT_ACT_OOR  = 1;
  localparam int unsigned BIT_SW_HOLD  = 7;
  localparam int unsigned BIT_SW_PWR   = 6;
  localparam int unsigned BIT_SW_DONE  = 4;
  localparam int unsigned BIT_SW_RDY   = 3;
  localparam int unsigned BIT_IRQ_FLAG = 0;
  localparam int unsigned BIT_IRQ_EN   = 1;
  localparam int unsigned SEL_LSB      = 0;   // Source in 6:4, divider in 3:0
  localparam int unsigned TRIM_W       = 6;

  // ---------------------------------------------------------------------------
  // Reset values and encodings
  // ---------------------------------------------------------------------------
  localparam logic        RST_PWR      = 1'b1;
  localparam logic [5:0]  RST_TRIM     = 6'h00;
  localparam logic [2:0]  SRC_EXT      = 3'h7;
  localparam logic [2:0]  SRC_FAST     = 3'h6;
  localparam logic [2:0]  SRC_SLOW     = 3'h5;
  localparam logic [2:0]  SRC_XTAL     = 3'h4;
  localparam logic [2:0]  SRC_EXT_PLL  = 3'h2;
  localparam logic [3:0]  DIV_MAX      = 4'h9;   // Divide by 512
  localparam logic [5:0]  TRIM_MAX     = 6'h1F;
  localparam logic [5:0]  TRIM_MIN     = 6'h20;

  // ---------------------------------------------------------------------------
  // Timing: reference rate and nominal fast oscillator rate
  // ---------------------------------------------------------------------------
  localparam int unsigned REF_FREQ_HZ  = 32768;
  localparam int unsigned FAST_FREQ_HZ = 32000000;
  localparam int unsigned EXP_COUNT    = FAST_FREQ_HZ / REF_FREQ_HZ;
  localparam int unsigned LOCK_TOL_PCT = 1;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] src;
    logic [3:0] div;
  } clk_sel_t;

  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_WAIT = 3'b010,
    SW_HELD = 3'b100
  } sw_state_t;

  // Only five source codes name a real oscillator
  function automatic logic src_valid(input logic [2:0] s);
    return (s == SRC_EXT) || (s == SRC_FAST) || (s == SRC_SLOW) ||
           (s == SRC_XTAL) || (s == SRC_EXT_PLL);
  endfunction

endpackage

// ---- verilog/osc_trim_switch.sv ----
// Auto-trim of the fast internal oscillator and clock switch control, APB slave
`timescale 1ns/1ps
`default_nettype none

module osc_trim_switch
  import osc_trim_pkg::*;
#(
  parameter int unsigned CNT_W   = 16,
  parameter int unsigned EXP_CNT = EXP_COUNT
) (
  input  wire logic              CLK,
  input  wire logic              ARST_N,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output var  logic [31:0]       PRDATA,
  output logic                   PREADY,
  output var  logic              PSLVERR,
  input  wire clk_sel_t          RESET_SEL_CFG,
  input  wire logic              SWITCH_PERMIT_CFG,
  input  wire logic              REF_CLK_IN,
  input  wire logic              FAST_OSC_TICK,
  input  wire logic              REQ_OSC_READY,
  output var  logic [TRIM_W-1:0] TRIM_CODE,
  output var  clk_sel_t          REQ_SEL,
  output var  clk_sel_t          ACTIVE_SEL,
  output var  logic              XTAL_HIGH_POWER,
  output var  logic              TRIM_IRQ
);

  // ---------------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------------
  localparam int unsigned TOL = (EXP_CNT * LOCK_TOL_PCT) / 100;
  generate
    if (EXP_CNT < 100 || EXP_CNT + TOL >= (1 << CNT_W) - 1) begin : g_bad_cnt
      $error("Expected count does not fit the counter or is too coarse for 1 percent");
    end
  endgenerate
  localparam logic [CNT_W-1:0] CNT_EXP = CNT_W'(EXP_CNT);
  localparam logic [CNT_W-1:0] CNT_LO  = CNT_W'(EXP_CNT - TOL);
  localparam logic [CNT_W-1:0] CNT_HI  = CNT_W'(EXP_CNT + TOL);

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n;
  // Two stages so that release never lands near a clock edge
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------------
  logic              auto_trim_enable;
  logic              trim_update_hold;
  logic              trim_locked;
  logic              trim_out_of_range;
  logic              trim_irq_flag;
  logic              trim_irq_enable;
  logic [TRIM_W-1:0] trim_r;
  logic              switch_hold;
  logic              crystal_power_select;
  logic              requested_ready;
  logic              strap_loaded_r;
  clk_sel_t          req_r;
  clk_sel_t          act_r;
  sw_state_t         sw_state_r;

  // Bus decode shared by the write and read paths
  logic       setup_ph;
  logic       wr_en;
  logic [9:0] idx;
  logic       aligned;
  logic       hit;
  assign setup_ph = PSEL && !PENABLE;
  assign wr_en    = PSEL && PENABLE && PWRITE;
  assign idx      = PADDR[ADDR_W-1:2];
  assign aligned  = (PADDR[1:0] == 2'b00);
  assign hit      = aligned && ((idx == IDX_REQ) || (idx == IDX_CUR) || (idx == IDX_SW) ||
                    (idx == IDX_TRIM) || (idx == IDX_ACT) || (idx == IDX_IRQ));

  // ---------------------------------------------------------------------------
  // Tuning measurement
  // ---------------------------------------------------------------------------
  logic             ref_d_r;
  logic             ref_rise;
  logic             armed_r;
  logic             tune_cycle;
  logic [CNT_W-1:0] fast_cnt_r;
  logic             too_slow;
  logic             too_fast;
  logic             lock_nxt;
  logic             oor_nxt;
  assign ref_rise   = REF_CLK_IN && !ref_d_r;
  // The first reference edge after enabling only opens a full measuring period
  assign tune_cycle = auto_trim_enable && ref_rise && armed_r;

  // Fast oscillator ticks counted over one reference period, saturating
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ref_d_r    <= 1'b0;
      armed_r    <= 1'b0;
      fast_cnt_r <= '0;
    end else begin
      ref_d_r <= REF_CLK_IN;
      if (!auto_trim_enable) begin
        armed_r    <= 1'b0;
        fast_cnt_r <= '0;
      end else if (ref_rise) begin
        armed_r    <= 1'b1;
        fast_cnt_r <= '0;
      end else if (FAST_OSC_TICK && fast_cnt_r != '1) begin
        fast_cnt_r <= fast_cnt_r + CNT_W'(1);
      end
    end
  end

  // Lock window and range decision at each tuning cycle
  always_comb begin
    too_slow = (fast_cnt_r < CNT_LO);
    too_fast = (fast_cnt_r > CNT_HI);
    lock_nxt = !too_slow && !too_fast;
    oor_nxt  = (too_slow && trim_r == TRIM_MAX) ||
               (too_fast && trim_r == TRIM_MIN);
  end

  // Status bits: hardware only; cleared while auto-trim is off
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      trim_locked       <= 1'b0;
      trim_out_of_range <= 1'b0;
    end else if (!auto_trim_enable) begin
      trim_locked       <= 1'b0;
      trim_out_of_range <= 1'b0;
    end else if (tune_cycle) begin
      trim_locked       <= lock_nxt;
      trim_out_of_range <= oor_nxt;
    end
  end

  // Trim code: hardware steps it, or software writes it, never both
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      trim_r <= RST_TRIM;
    end else if (auto_trim_enable) begin
      if (tune_cycle && !trim_update_hold) begin
        // Signed step; the limits saturate rather than wrap
        if (fast_cnt_r < CNT_EXP && trim_r != TRIM_MAX) begin
          trim_r <= trim_r + 6'h01;
        end else if (fast_cnt_r > CNT_EXP && trim_r != TRIM_MIN) begin
          trim_r <= trim_r - 6'h01;
        end
      end
    end else if (wr_en && aligned && idx == IDX_TRIM && !trim_update_hold) begin
      trim_r <= PWDATA[TRIM_W-1:0];
    end
  end
  assign TRIM_CODE = trim_r;

  // Control bits of the trimmer; flag set wins over a write-one clear
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      auto_trim_enable <= 1'b0;
      trim_update_hold <= 1'b0;
      trim_irq_flag    <= 1'b0;
      trim_irq_enable  <= 1'b0;
    end else begin
      if (wr_en && aligned && idx == IDX_ACT) begin
        auto_trim_enable <= PWDATA[BIT_ACT_EN];
        trim_update_hold <= PWDATA[BIT_ACT_HOLD];
      end
      if (wr_en && aligned && idx == IDX_IRQ) begin
        trim_irq_enable <= PWDATA[BIT_IRQ_EN];
      end
      if (tune_cycle && (lock_nxt != trim_locked || oor_nxt != trim_out_of_range)) begin
        trim_irq_flag <= 1'b1;
      end else if (wr_en && aligned && idx == IDX_IRQ && PWDATA[BIT_IRQ_FLAG]) begin
        trim_irq_flag <= 1'b0;
      end
    end
  end
  assign TRIM_IRQ = trim_irq_flag && trim_irq_enable;

  // ---------------------------------------------------------------------------
  // Clock selection
  // ---------------------------------------------------------------------------
  logic sw_done;
  logic req_wr_ok;
  assign sw_done   = (req_r == act_r);
  // A reserved source drops the whole byte; so does a locked-down switch
  assign req_wr_ok = wr_en && aligned && idx == IDX_REQ && SWITCH_PERMIT_CFG &&
                     src_valid(PWDATA[6:4]) && (PWDATA[3:0] <= DIV_MAX);

  // Request fields; straps are caught on the first edge after release
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      strap_loaded_r <= 1'b0;
      req_r          <= '0;
    end else if (!strap_loaded_r || !SWITCH_PERMIT_CFG) begin
      strap_loaded_r <= 1'b1;
      req_r          <= RESET_SEL_CFG;
    end else if (req_wr_ok) begin
      req_r <= PWDATA[6:0];
    end
  end

  // Switch sequencer: wait for readiness, optionally hold, then copy
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      sw_state_r      <= SW_IDLE;
      act_r           <= '0;
      requested_ready <= 1'b0;
    end else if (!strap_loaded_r) begin
      act_r <= RESET_SEL_CFG;
    end else begin
      case (sw_state_r)
        SW_IDLE: begin
          requested_ready <= 1'b0;
          if (!sw_done) begin
            sw_state_r <= SW_WAIT;
          end
        end
        SW_WAIT: begin
          if (sw_done) begin
            sw_state_r <= SW_IDLE;
          end else if (REQ_OSC_READY && !switch_hold) begin
            act_r      <= req_r;
            sw_state_r <= SW_IDLE;
          end else if (REQ_OSC_READY) begin
            requested_ready <= 1'b1;
            sw_state_r      <= SW_HELD;
          end
        end
        SW_HELD: begin
          // Abandoned by copying active back, or released by clearing hold
          if (sw_done) begin
            requested_ready <= 1'b0;
            sw_state_r      <= SW_IDLE;
          end else if (!switch_hold) begin
            act_r           <= req_r;
            requested_ready <= 1'b0;
            sw_state_r      <= SW_IDLE;
          end
        end
        default: begin
          sw_state_r      <= SW_IDLE;
          requested_ready <= 1'b0;
        end
      endcase
    end
  end

  // Switch control byte: hold and crystal power are plain software bits
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      switch_hold          <= 1'b0;
      crystal_power_select <= RST_PWR;
    end else if (wr_en && aligned && idx == IDX_SW) begin
      switch_hold          <= PWDATA[BIT_SW_HOLD];
      crystal_power_select <= PWDATA[BIT_SW_PWR];
    end
  end
  assign REQ_SEL         = req_r;
  assign ACTIVE_SEL      = act_r;
  assign XTAL_HIGH_POWER = crystal_power_select;

  // ---------------------------------------------------------------------------
  // APB read path: data captured in the setup cycle, answered with no wait
  // ---------------------------------------------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      IDX_REQ:  rd_byte = {1'b0, req_r};
      IDX_CUR:  rd_byte = {1'b0, act_r};
      IDX_SW:   rd_byte = {switch_hold, crystal_power_select, 1'b0, sw_done,
                           requested_ready, 3'b000};
      IDX_TRIM: rd_byte = {2'b00, trim_r};
      IDX_ACT:  rd_byte = {auto_trim_enable, trim_update_hold, 2'b00, trim_locked,
                           1'b0, trim_out_of_range, 1'b0};
      IDX_IRQ:  rd_byte = {6'h00, trim_irq_enable, trim_irq_flag};
      default:  rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (setup_ph) begin
      PRDATA  <= (hit && !PWRITE) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      PSLVERR <= !hit;
    end
  end
  assign PREADY = PSEL && PENABLE;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_trim_sw_blocked;
    @(posedge CLK) disable iff (!rst_n)
      (wr_en && aligned && idx == IDX_TRIM && (auto_trim_enable || trim_update_hold) &&
       !tune_cycle) |=> $stable(trim_r);
  endproperty
  a_trim_sw_blocked: assert property (p_trim_sw_blocked) else $error("trim took a blocked write");

  property p_trim_sw_write;
    @(posedge CLK) disable iff (!rst_n)
      (wr_en && aligned && idx == IDX_TRIM && !auto_trim_enable && !trim_update_hold)
      |=> (trim_r == $past(PWDATA[5:0]));
  endproperty
  a_trim_sw_write: assert property (p_trim_sw_write) else $error("software trim write lost");

  property p_lock_off;
    @(posedge CLK) disable iff (!rst_n)
      !auto_trim_enable |=> !trim_locked && !trim_out_of_range;
  endproperty
  a_lock_off: assert property (p_lock_off) else $error("status bits set with auto-trim off");

  property p_step_one;
    @(posedge CLK) disable iff (!rst_n)
      (auto_trim_enable && $changed(trim_r)) |->
        ($past(tune_cycle) && !$past(trim_update_hold) &&
         (trim_r - $past(trim_r) == 6'h01 || $past(trim_r) - trim_r == 6'h01));
  endproperty
  a_step_one: assert property (p_step_one) else $error("trim moved off a tuning cycle step");

  property p_hold_freeze;
    @(posedge CLK) disable iff (!rst_n)
      (auto_trim_enable && trim_update_hold) [*2] |-> $stable(trim_r);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("trim changed under update hold");

  property p_flag_on_change;
    @(posedge CLK) disable iff (!rst_n)
      (tune_cycle && lock_nxt != trim_locked) |=> trim_irq_flag;
  endproperty
  a_flag_on_change: assert property (p_flag_on_change) else $error("lock change raised no flag");

  property p_irq_follows;
    @(posedge CLK) disable iff (!rst_n)
      TRIM_IRQ == (trim_irq_flag && trim_irq_enable);
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt does not follow flag");

  property p_reserved_src;
    @(posedge CLK) disable iff (!rst_n)
      (strap_loaded_r && SWITCH_PERMIT_CFG && wr_en && aligned && idx == IDX_REQ &&
       !src_valid(PWDATA[6:4])) |=> $stable(req_r);
  endproperty
  a_reserved_src: assert property (p_reserved_src) else $error("reserved source was written");

  property p_no_permit;
    @(posedge CLK) disable iff (!rst_n)
      (strap_loaded_r && !SWITCH_PERMIT_CFG) |=> (req_r == $past(RESET_SEL_CFG));
  endproperty
  a_no_permit: assert property (p_no_permit) else $error("request moved without permit");

  property p_hold_blocks;
    @(posedge CLK) disable iff (!rst_n)
      (sw_state_r == SW_HELD && switch_hold && !sw_done) |=> $stable(act_r) && requested_ready;
  endproperty
  a_hold_blocks: assert property (p_hold_blocks) else $error("switch completed under hold");

  property p_switch_now;
    @(posedge CLK) disable iff (!rst_n)
      (sw_state_r == SW_WAIT && !sw_done && REQ_OSC_READY && !switch_hold)
      |=> sw_done && !requested_ready ##1 sw_state_r == SW_IDLE;
  endproperty
  a_switch_now: assert property (p_switch_now) else $error("switch did not complete on ready");

  c_lock:    cover property (@(posedge CLK) disable iff (!rst_n) $rose(trim_locked));
  c_oor:     cover property (@(posedge CLK) disable iff (!rst_n) $rose(trim_out_of_range));
  c_held:    cover property (@(posedge CLK) disable iff (!rst_n)
                             sw_state_r == SW_HELD ##1 sw_state_r == SW_IDLE);
  c_switch:  cover property (@(posedge CLK) disable iff (!rst_n) $changed(act_r));

endmodule

`default_nettype wire
